// file: hw/supply_supervisor_reset_watchdog.sv
// digital core of the supply supervisor with reset hold and watchdog
// Behaviour
// - a rising or a falling edge on the watchdog kick input retriggers the watchdog.
// - a watchdog time-out without a kick asserts reset for the hold period.
// - a time-out that resets also restarts the watchdog for a full new interval.
// - manual reset low asserts reset, held while low and for the hold period after.
// - a bouncing manual reset is tolerated; each low restarts and hold counts from final release.
// - the power-fail flag goes low when the power-fail comparator reports below threshold.
// - the power-fail flag returns high only when the comparator reports above threshold plus hysteresis.
// - the power-fail flag is an open-drain output following its comparator, not stretched.
// - the aux sense input below threshold asserts its associated reset.
// - in the dual variant supply reset follows the supply and manual reset, aux reset the sense input and manual reset.
// - in the watchdog variant reset asserts on sense low, supply low or manual reset low.
// - after the sense input recovers its reset stays active for the hold delay.
// - in the dual variant manual reset low forces both reset outputs.
`timescale 1ns/10ps
module supply_supervisor_reset_watchdog #(
   parameter supervisor_pkg::variant_e VARIANT = supervisor_pkg::VAR_WATCHDOG,
   parameter int unsigned TICK_DIV = supervisor_pkg::TICK_DIV,
   parameter int unsigned HOLD = supervisor_pkg::HOLD_TICKS,
   parameter int unsigned WDOG = supervisor_pkg::WDOG_TICKS
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic supply_cmp_in,
   input wire logic aux_cmp_in,
   input wire logic powerfail_cmp_in,
   input wire logic manual_reset_in_n,
   input wire logic wdog_kick_in,
   output logic supply_reset_out_n,
   output logic aux_reset_out_n,
   output logic powerfail_flag_out_n,
   output logic powerfail_flag_oe
);
   import supervisor_pkg::*;

   // --------------------------------------------------------------
   // parameter checks
   // --------------------------------------------------------------
   if (TICK_DIV < 1) begin : gBadDiv
      $error("TICK_DIV must be at least 1");
   end
   if (HOLD < 1) begin : gBadHold
      $error("HOLD must be at least 1");
   end
   if (WDOG < 1) begin : gBadWdog
      $error("WDOG must be at least 1");
   end
   if (HOLD > 32'h7FFF_FFFF || WDOG > 32'h7FFF_FFFF) begin : gBadSize
      $error("HOLD and WDOG must stay below 2**31");
   end
   if (VARIANT != VAR_POWERFAIL && VARIANT != VAR_DUAL
       && VARIANT != VAR_WATCHDOG) begin : gBadVariant
      $error("VARIANT is not a supported variant");
   end

   // --------------------------------------------------------------
   // variant decoding
   // --------------------------------------------------------------
   function automatic logic is_variant(input variant_e which);
      return VARIANT == which;
   endfunction

   // --------------------------------------------------------------
   // input synchronisers
   // --------------------------------------------------------------
   sense_s rawIn;
   sense_s syncA;
   sense_s syncB;
   logic kickLast;

   always_comb begin
      rawIn = '{supplyOk: supply_cmp_in, auxOk: aux_cmp_in,
                powerfailOk: powerfail_cmp_in, manualResetN: manual_reset_in_n,
                wdogKick: wdog_kick_in};
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         syncA <= sense_s'(SENSE_RESET);
         syncB <= sense_s'(SENSE_RESET);
         kickLast <= 1'b0;
      end else begin
         syncA <= rawIn;
         syncB <= syncA;
         kickLast <= syncB.wdogKick;
      end
   end

   // --------------------------------------------------------------
   // timebase tick
   // --------------------------------------------------------------
   localparam int unsigned DW = $clog2(TICK_DIV + 1);
   localparam logic [DW-1:0] DIV_LAST = DW'(TICK_DIV - 1);
   logic [DW-1:0] divCount;
   logic [DW-1:0] next_divCount;
   logic tick;
   logic next_tick;

   always_comb begin
      next_tick = (divCount == DIV_LAST);
      next_divCount = next_tick ? '0 : divCount + 1'b1;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         divCount <= '0;
         tick <= 1'b0;
      end else begin
         divCount <= next_divCount;
         tick <= next_tick;
      end
   end

   // --------------------------------------------------------------
   // watchdog
   // --------------------------------------------------------------
   localparam int unsigned WW = $clog2(WDOG + 1);
   localparam logic [WW-1:0] WDOG_LOAD = WW'(WDOG);
   logic [WW-1:0] wdogCount;
   logic [WW-1:0] next_wdogCount;
   logic wdogFire;
   logic next_wdogFire;
   logic kickEdge;
   logic wdogOn;
   logic holdSupply;
   logic holdAux;

   always_comb begin
      wdogOn = is_variant(VAR_WATCHDOG);
      kickEdge = syncB.wdogKick ^ kickLast;
      next_wdogFire = 1'b0;
      next_wdogCount = wdogCount;
      if (!wdogOn || holdSupply || kickEdge) begin
         next_wdogCount = WDOG_LOAD;
      end else if (tick) begin
         if (wdogCount <= 1) begin
            next_wdogFire = 1'b1;
            next_wdogCount = WDOG_LOAD;
         end else begin
            next_wdogCount = wdogCount - 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wdogCount <= WDOG_LOAD;
         wdogFire <= 1'b0;
      end else begin
         wdogCount <= next_wdogCount;
         wdogFire <= next_wdogFire;
      end
   end

   // --------------------------------------------------------------
   // reset causes and hold timers
   // --------------------------------------------------------------
   logic manualLow;
   logic supplyCause;
   logic auxCause;

   always_comb begin
      manualLow = !syncB.manualResetN;
      case (VARIANT)
         VAR_DUAL: begin
            supplyCause = !syncB.supplyOk || manualLow;
            auxCause = !syncB.auxOk || manualLow;
         end
         VAR_WATCHDOG: begin
            supplyCause = !syncB.supplyOk || !syncB.auxOk || manualLow || wdogFire;
            auxCause = 1'b0;
         end
         default: begin
            supplyCause = !syncB.supplyOk || manualLow;
            auxCause = 1'b0;
         end
      endcase
   end

   hold_timer #(.HOLD(HOLD)) supplyHold (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tick(tick),
      .cause(supplyCause),
      .active(holdSupply)
   );

   hold_timer #(.HOLD(HOLD)) auxHold (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tick(tick),
      .cause(auxCause),
      .active(holdAux)
   );

   // --------------------------------------------------------------
   // output registers
   // --------------------------------------------------------------
   logic next_auxResetN;
   logic next_pfOe;

   always_comb begin
      next_auxResetN = is_variant(VAR_DUAL) ? !holdAux : 1'b1;
      next_pfOe = is_variant(VAR_POWERFAIL) && !syncB.powerfailOk;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         supply_reset_out_n <= 1'b0;
         aux_reset_out_n <= 1'b0;
         powerfail_flag_out_n <= 1'b0;
         powerfail_flag_oe <= 1'b0;
      end else begin
         supply_reset_out_n <= !holdSupply;
         aux_reset_out_n <= next_auxResetN;
         powerfail_flag_out_n <= 1'b0;
         powerfail_flag_oe <= next_pfOe;
      end
   end
endmodule // supply_supervisor_reset_watchdog

// file: hw/supervisor_pkg.sv
// constants and carriers of the supply supervisor core
package supervisor_pkg;
   // --------------------------------------------------------------
   // timebase and delays
   // --------------------------------------------------------------
   localparam int unsigned CLK_FREQ_HZ = 250_000_000;
   localparam int unsigned TICK_NS = 1_000;
   localparam int unsigned TICK_DIV = CLK_FREQ_HZ / 1_000_000 * TICK_NS / 1_000;
   localparam int unsigned HOLD_TIME_US = 130_000;
   localparam int unsigned WDOG_TIMEOUT_US = 1_100_000;
   localparam int unsigned HOLD_TICKS = HOLD_TIME_US * 1_000 / TICK_NS;
   localparam int unsigned WDOG_TICKS = WDOG_TIMEOUT_US * 1_000 / TICK_NS;
   localparam int unsigned SYNC_STAGES = 2;

   // --------------------------------------------------------------
   // variants and carriers
   // --------------------------------------------------------------
   typedef enum logic [1:0] {
      VAR_POWERFAIL = 2'h0,
      VAR_DUAL = 2'h1,
      VAR_WATCHDOG = 2'h2
   } variant_e;

   typedef struct packed {
      logic supplyOk;
      logic auxOk;
      logic powerfailOk;
      logic manualResetN;
      logic wdogKick;
   } sense_s;

   localparam int unsigned SENSE_W = $bits(sense_s);
   // all comparators good, manual reset released, kick low
   localparam logic [SENSE_W-1:0] SENSE_RESET = 5'h1E;
endpackage

// file: hw/hold_timer.sv
// reset hold stretcher driven by the internal tick
`timescale 1ns/10ps
module hold_timer #(
   parameter int unsigned HOLD = 130_000
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic cause,
   output logic active
);
   import supervisor_pkg::*;

   if (HOLD < 1) begin : gBadHold
      $error("hold_timer: HOLD must be at least 1");
   end

   localparam int unsigned CW = $clog2(HOLD + 1);
   localparam logic [CW-1:0] LOAD = CW'(HOLD);

   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic next_active;

   always_comb begin
      next_count = count;
      next_active = active;
      if (cause) begin
         next_count = LOAD;
         next_active = 1'b1;
      end else if (count != '0) begin
         if (tick) next_count = count - 1'b1;
         next_active = 1'b1;
      end else begin
         next_active = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= LOAD;
         active <= 1'b1;
      end else begin
         count <= next_count;
         active <= next_active;
      end
   end
endmodule // hold_timer

// file: test/supervisor_props.sv
// assertions on the ports of the supply supervisor core
`timescale 1ns/10ps
module supervisor_props
   import supervisor_pkg::*;
#(
   parameter variant_e VARIANT = VAR_WATCHDOG,
   parameter int unsigned HOLD = 8,
   parameter int unsigned WDOG = 20
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic supply_cmp_in,
   input wire logic aux_cmp_in,
   input wire logic powerfail_cmp_in,
   input wire logic manual_reset_in_n,
   input wire logic wdog_kick_in,
   input wire logic supply_reset_out_n,
   input wire logic aux_reset_out_n,
   input wire logic powerfail_flag_out_n,
   input wire logic powerfail_flag_oe
);
   // counts assume one tick per clock
   localparam bit WD = VARIANT == VAR_WATCHDOG;
   localparam bit DU = VARIANT == VAR_DUAL;
   localparam bit PF = VARIANT == VAR_POWERFAIL;
   int lowCnt, goodCnt, quietCnt;
   logic kickPrev;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lowCnt <= 0;
         goodCnt <= 0;
         quietCnt <= 0;
         kickPrev <= 1'b0;
      end else begin
         lowCnt <= supply_reset_out_n ? 0 : lowCnt + 1;
         goodCnt <= (manual_reset_in_n && supply_cmp_in && (aux_cmp_in || !WD)) ? goodCnt + 1 : 0;
         quietCnt <= (supply_reset_out_n && wdog_kick_in == kickPrev) ? quietCnt + 1 : 0;
         kickPrev <= wdog_kick_in;
      end
   end
   default clocking dc @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   mr_forces_a: assert property ((!manual_reset_in_n) [*4] |-> ##[0:2]
      (!supply_reset_out_n && (!DU || !aux_reset_out_n))) else $error("manual reset ignored");
   supply_cause_a: assert property ((!supply_cmp_in) [*4] |-> ##[0:2] !supply_reset_out_n)
      else $error("supply low ignored");
   aux_cause_a: assert property (((WD || DU) && !aux_cmp_in) [*4] |-> ##[0:2]
      !(WD ? supply_reset_out_n : aux_reset_out_n)) else $error("sense low ignored");
   hold_min_a: assert property ($rose(supply_reset_out_n) |-> lowCnt >= HOLD - 1)
      else $error("hold too short");
   hold_end_a: assert property (goodCnt == HOLD + 6 |-> supply_reset_out_n)
      else $error("hold too long");
   wdog_fire_a: assert property (WD |-> quietCnt <= WDOG + 9)
      else $error("watchdog did not fire");
   wdog_full_a: assert property (WD && $fell(supply_reset_out_n) && goodCnt > HOLD + 10
      |-> quietCnt >= WDOG - 3) else $error("watchdog fired early");
   pf_low_a: assert property ((PF && !powerfail_cmp_in) [*3] |-> ##[0:1]
      (powerfail_flag_oe && !powerfail_flag_out_n)) else $error("flag not pulled");
   pf_high_a: assert property ((PF && powerfail_cmp_in) [*3] |-> ##[0:1] !powerfail_flag_oe)
      else $error("flag not released");
   wdog_c: cover property (WD && $fell(supply_reset_out_n) && goodCnt > HOLD + 10);
   pf_c: cover property ($rose(powerfail_flag_oe));
   hold_c: cover property ($rose(supply_reset_out_n));
endmodule // supervisor_props

// file: test/dsp_kicker.sv
// processor model that toggles the watchdog kick while out of reset
`timescale 1ns/10ps
module dsp_kicker #(
   parameter int PERIOD = 6
) (
   input wire logic ref_clk,
   input wire logic resetIn_n,
   input wire logic enable,
   output logic kick
);
   int cnt = 0;
   always @(posedge ref_clk) begin
      if (!resetIn_n) begin
         cnt <= 0;
         kick <= 1'b0;
      end else if (!enable) begin
         cnt <= 0;
      end else if (cnt == PERIOD - 1) begin
         cnt <= 0;
         kick <= !kick;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule // dsp_kicker

// file: test/testbench.sv
// self-checking bench for the supply supervisor core, all three variants
`timescale 1ns/10ps
module testbench;
   import supervisor_pkg::*;
   localparam int unsigned HOLD = 8;
   localparam int unsigned WDOG = 20;
   localparam logic [4:0] CAUSE [4] = '{5'h1C, 5'h0E, 5'h16, 5'h1A};
   localparam logic [4:0] LOW [4] = '{5'h00, 5'h04, 5'h0A, 5'h1F};
   localparam logic [4:0] HELD [4] = '{5'h00, 5'h04, 5'h0A, 5'h1E};
   logic ref_clk = 1'b0;
   logic rst_n;
   logic kickOn = 1'b1;
   logic kick;
   logic sampleNow = 1'b0;
   sense_s sense = 5'h1E;
   logic [2:0] rstS, rstA, pfN, pfOe;
   logic [4:0] got, expv;
   logic [4:0] q[$];
   int failures = 0, n_tests = 0, cycles = 0, seed = 32;
   initial forever #2 ref_clk = !ref_clk;
   for (genvar g = 0; g < 3; g++) begin : gVar
      supply_supervisor_reset_watchdog #(.VARIANT(variant_e'(g)), .TICK_DIV(1), .HOLD(HOLD),
         .WDOG(WDOG)) i_supply_supervisor_reset_watchdog (.ref_clk(ref_clk), .rst_n(rst_n),
         .supply_cmp_in(sense.supplyOk), .aux_cmp_in(sense.auxOk),
         .powerfail_cmp_in(sense.powerfailOk), .manual_reset_in_n(sense.manualResetN),
         .wdog_kick_in(kick), .supply_reset_out_n(rstS[g]), .aux_reset_out_n(rstA[g]),
         .powerfail_flag_out_n(pfN[g]), .powerfail_flag_oe(pfOe[g]));
   end
   // one toggle per 12 cycles: a watchdog taking only one edge kind would time out
   dsp_kicker #(.PERIOD(12)) i_dsp_kicker (.ref_clk(ref_clk), .resetIn_n(rstS[2]),
      .enable(kickOn), .kick(kick));
   assign got = {rstS[2], rstS[1], rstA[1], rstS[0], pfOe[0]};
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic [4:0] e);
      q.push_back(e);
      sampleNow <= 1'b1;
      @(posedge ref_clk);
      sampleNow <= 1'b0;
   endtask
   task automatic drive(input logic [4:0] s, input int n);
      sense <= sense_s'(s);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic await_wd(input logic lvl, input int lim);
      while (rstS[2] !== lvl && lim > 0) begin
         @(posedge ref_clk);
         lim--;
      end
   endtask
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (sampleNow) begin
         expv = q.pop_front();
         n_tests++;
         if (got !== expv) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, expv);
         end
      end
      if (cycles == 2000) begin
         failures++;
         wrap_up();
      end
   end
   initial begin
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      drive(5'h1E, HOLD - 3);
      check(5'h00);
      drive(5'h1E, HOLD);
      check(5'h1E);
      for (int i = 0; i < 4; i++) begin
         drive(CAUSE[i], 6);
         check(LOW[i]);
         drive(5'h1E, HOLD - 3);
         check(HELD[i]);
         drive(5'h1E, HOLD + 2);
         check(5'h1E);
      end
      repeat (6) begin
         drive(5'h1C, 1 + $unsigned($random(seed)) % 3);
         drive(5'h1E, 1 + $unsigned($random(seed)) % 3);
      end
      drive(5'h1E, HOLD - 4);
      check(5'h00);
      drive(5'h1E, HOLD + 2);
      check(5'h1E);
      kickOn <= 1'b0;
      await_wd(1'b0, WDOG + 12);
      check(5'h0E);
      await_wd(1'b1, HOLD + 6);
      drive(5'h1E, WDOG - 4);
      check(5'h1E);
      await_wd(1'b0, 12);
      check(5'h0E);
      kickOn <= 1'b1;
      drive(5'h1E, HOLD + 2 * WDOG);
      check(5'h1E);
      wrap_up();
   end
endmodule // testbench
bind supply_supervisor_reset_watchdog supervisor_props #(.VARIANT(VARIANT), .HOLD(HOLD),
   .WDOG(WDOG)) i_supervisor_props (.ref_clk, .rst_n, .supply_cmp_in, .aux_cmp_in,
   .powerfail_cmp_in, .manual_reset_in_n, .wdog_kick_in, .supply_reset_out_n,
   .aux_reset_out_n, .powerfail_flag_out_n, .powerfail_flag_oe);
